// *** rtl/edge_irq_regs.svh ***
`ifndef EDGE_IRQ_REGS_SVH
`define EDGE_IRQ_REGS_SVH

// register indices on the internal register port
`define EDGE_SEL_LOW_ADDR 6'h25
`define EDGE_SEL_DUAL_ADDR 6'h26
`define EDGE_SEL_RESET 24'h000000

// field geometry
`define SINGLE_CHANS 12
`define DUAL_CHANS 6
`define SINGLE_FIELD_W 2
`define DUAL_FIELD_W 4

// 2-bit selection codes
`define SEL_NONE 2'h0
`define SEL_RISE 2'h1
`define SEL_FALL 2'h2
`define SEL_BOTH 2'h3

`endif

// *** rtl/edge_irq_pkg.sv ***
package edge_irq_pkg;

	// one register access from the serial front end
	typedef struct packed {
		logic wr;
		logic [5:0] addr;
		logic [23:0] wdata;
	} reg_req_s;

	// one crossing event: which inputs rose above and fell below
	typedef struct packed {
		logic [17:0] rise;
		logic [17:0] fall;
	} cross_s;

endpackage : edge_irq_pkg

// *** rtl/edge_irq_select.sv ***
`include "edge_irq_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module edge_irq_select (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// register port from the serial front end
	input wire edge_irq_pkg::reg_req_s reg_req,
	input wire logic reg_req_valid,
	output logic [23:0] reg_rdata,
	// comparator results, one bit per input, high while above threshold
	input wire logic sample_valid,
	input wire logic [11:0] above_assigned_threshold,
	input wire logic [5:0] above_pair_threshold_first,
	input wire logic [5:0] above_pair_threshold_second,
	// crossing flags, one-cycle pulses per input
	output logic [11:0] chan_irq_event,
	output logic [5:0] dual_irq_event_first,
	output logic [5:0] dual_irq_event_second,
	output logic irq_any
);

	////////////////////////////////////////////////////////////////////////////////
	// registers

	logic [23:0] sel_low_q, sel_low_d;
	logic [23:0] sel_dual_q, sel_dual_d;
	logic [23:0] rdata_q, rdata_d;

	always_comb begin
		sel_low_d = sel_low_q;
		sel_dual_d = sel_dual_q;
		rdata_d = rdata_q;
		if (reg_req_valid) begin
			if (reg_req.addr == `EDGE_SEL_LOW_ADDR) begin
				rdata_d = sel_low_q;
				if (reg_req.wr)
					sel_low_d = reg_req.wdata;
			end else if (reg_req.addr == `EDGE_SEL_DUAL_ADDR) begin
				rdata_d = sel_dual_q;
				if (reg_req.wr)
					sel_dual_d = reg_req.wdata;
			end else begin
				// other offsets belong to other blocks; read as zero here
				rdata_d = 24'h000000;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sel_low_q <= `EDGE_SEL_RESET;
			sel_dual_q <= `EDGE_SEL_RESET;
			rdata_q <= 24'h000000;
		end else begin
			sel_low_q <= sel_low_d;
			sel_dual_q <= sel_dual_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// crossing detection

	// first sample after reset only primes the history, so power-up levels raise nothing
	logic primed_q, primed_d;
	logic [11:0] prev_low_q, prev_low_d;
	logic [5:0] prev_a_q, prev_a_d;
	logic [5:0] prev_b_q, prev_b_d;
	logic [11:0] ev_low_q, ev_low_d;
	logic [5:0] ev_a_q, ev_a_d;
	logic [5:0] ev_b_q, ev_b_d;
	edge_irq_pkg::cross_s cross_a, cross_b;
	logic [11:0] rise_low, fall_low;

	function automatic logic pick(input logic [1:0] sel, input logic rise, input logic fall);
		logic r;
		r = 1'b0;
		unique case (sel)
			`SEL_NONE: r = 1'b0;
			`SEL_RISE: r = rise;
			`SEL_FALL: r = fall;
			`SEL_BOTH: r = rise | fall;
		endcase
		return r;
	endfunction : pick

	always_comb begin
		rise_low = above_assigned_threshold & ~prev_low_q;
		fall_low = ~above_assigned_threshold & prev_low_q;
		cross_a.rise = {12'h000, above_pair_threshold_first & ~prev_a_q};
		cross_a.fall = {12'h000, ~above_pair_threshold_first & prev_a_q};
		cross_b.rise = {12'h000, above_pair_threshold_second & ~prev_b_q};
		cross_b.fall = {12'h000, ~above_pair_threshold_second & prev_b_q};
		prev_low_d = prev_low_q;
		prev_a_d = prev_a_q;
		prev_b_d = prev_b_q;
		primed_d = primed_q;
		ev_low_d = 12'h000;
		ev_a_d = 6'h00;
		ev_b_d = 6'h00;
		if (sample_valid) begin
			prev_low_d = above_assigned_threshold;
			prev_a_d = above_pair_threshold_first;
			prev_b_d = above_pair_threshold_second;
			primed_d = 1'b1;
			if (primed_q) begin
				for (int i = 0; i < `SINGLE_CHANS; i++)
					ev_low_d[i] = pick(sel_low_q[2*i +: 2], rise_low[i], fall_low[i]);
				for (int j = 0; j < `DUAL_CHANS; j++) begin
					ev_a_d[j] = pick(sel_dual_q[4*j +: 2], cross_a.rise[j], cross_a.fall[j]);
					ev_b_d[j] = pick(sel_dual_q[4*j+2 +: 2], cross_b.rise[j], cross_b.fall[j]);
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			primed_q <= 1'b0;
			prev_low_q <= 12'h000;
			prev_a_q <= 6'h00;
			prev_b_q <= 6'h00;
			ev_low_q <= 12'h000;
			ev_a_q <= 6'h00;
			ev_b_q <= 6'h00;
		end else begin
			primed_q <= primed_d;
			prev_low_q <= prev_low_d;
			prev_a_q <= prev_a_d;
			prev_b_q <= prev_b_d;
			ev_low_q <= ev_low_d;
			ev_a_q <= ev_a_d;
			ev_b_q <= ev_b_d;
		end
	end

	assign chan_irq_event = ev_low_q;
	assign dual_irq_event_first = ev_a_q;
	assign dual_irq_event_second = ev_b_q;
	assign irq_any = |{ev_low_q, ev_a_q, ev_b_q};

	////////////////////////////////////////////////////////////////////////////////
	// checks

	disabled_chan_quiet_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(sel_low_q[1:0] == `SEL_NONE) |=> !chan_irq_event[0])
		else $error("input 0 flagged while disabled");

	rise_only_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(sel_low_q[3:2] == `SEL_RISE) && sample_valid && primed_q && above_assigned_threshold[1] && !prev_low_q[1]
		|=> chan_irq_event[1])
		else $error("rising crossing of input 1 not flagged");

	fall_only_a: assert property (@(posedge mclk) disable iff (!reset_n)
		chan_irq_event[2] && ($past(sel_low_q[5:4]) == `SEL_FALL) |-> !$past(above_assigned_threshold[2]))
		else $error("input 2 flagged without falling crossing");

	both_dirs_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(sel_low_q[23:22] == `SEL_BOTH) && sample_valid && primed_q
		&& (above_assigned_threshold[11] != prev_low_q[11]) |=> chan_irq_event[11])
		else $error("input 11 crossing missed in both mode");

	dual_high_field_a: assert property (@(posedge mclk) disable iff (!reset_n)
		reg_req_valid && reg_req.wr && reg_req.addr == `EDGE_SEL_DUAL_ADDR
		|=> sel_dual_q[23:12] == $past(reg_req.wdata[23:12]))
		else $error("dual register upper fields not written");

	first_pair_a: assert property (@(posedge mclk) disable iff (!reset_n)
		dual_irq_event_first[0] |-> $past(sel_dual_q[1:0]) != `SEL_NONE)
		else $error("input 12 first threshold flagged while disabled");

	second_pair_a: assert property (@(posedge mclk) disable iff (!reset_n)
		dual_irq_event_second[5] |-> $past(sel_dual_q[23:22]) != `SEL_NONE)
		else $error("input 17 second threshold flagged while disabled");

	dual_low_field_a: assert property (@(posedge mclk) disable iff (!reset_n)
		reg_req_valid && !reg_req.wr && reg_req.addr == `EDGE_SEL_DUAL_ADDR
		|=> reg_rdata[11:0] == $past(sel_dual_q[11:0]))
		else $error("dual register lower fields read back wrong");

	no_sample_quiet_a: assert property (@(posedge mclk) disable iff (!reset_n)
		!sample_valid |=> !irq_any)
		else $error("event flagged without a new sample");

	unprimed_quiet_a: assert property (@(posedge mclk) disable iff (!reset_n)
		sample_valid && !primed_q |=> !irq_any)
		else $error("event flagged on the priming sample");

	low_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
		reg_req_valid && reg_req.wr && reg_req.addr == `EDGE_SEL_LOW_ADDR
		|=> sel_low_q == $past(reg_req.wdata))
		else $error("low register not written");

	sel_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
		!(reg_req_valid && reg_req.wr) |=> $stable(sel_low_q) && $stable(sel_dual_q))
		else $error("selection changed without a write");

	// unmapped offsets must not echo a selection register
	unknown_addr_zero_a: assert property (@(posedge mclk) disable iff (!reset_n)
		reg_req_valid && reg_req.addr != `EDGE_SEL_LOW_ADDR && reg_req.addr != `EDGE_SEL_DUAL_ADDR
		|=> reg_rdata == 24'h000000)
		else $error("unmapped offset read back nonzero");

	first_rise_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(sel_dual_q[1:0] == `SEL_RISE) && sample_valid && primed_q
		&& above_pair_threshold_first[0] && !prev_a_q[0]
		|=> dual_irq_event_first[0])
		else $error("input 12 first threshold rise not flagged");

	second_rise_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(sel_dual_q[23:22] == `SEL_RISE) && sample_valid && primed_q
		&& above_pair_threshold_second[5] && !prev_b_q[5]
		|=> dual_irq_event_second[5])
		else $error("input 17 second threshold rise not flagged");

	chan13_both_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(sel_dual_q[7:6] == `SEL_BOTH) && sample_valid && primed_q
		&& (above_pair_threshold_second[1] != prev_b_q[1])
		|=> dual_irq_event_second[1])
		else $error("input 13 second threshold crossing missed");

endmodule : edge_irq_select

// *** bench/host_model.sv ***
module host_model (
	// clock
	input wire logic mclk,
	// register port toward the block
	output edge_irq_pkg::reg_req_s reg_req,
	output logic reg_req_valid,
	input wire logic [23:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		reg_req = '0;
		reg_req_valid = 1'b0;
	end
	task acc(input logic wr, input logic [5:0] addr, input logic [23:0] wdata, output logic [23:0] rdata);
		@(negedge mclk);
		reg_req = '{wr: wr, addr: addr, wdata: wdata};
		reg_req_valid = 1'b1;
		@(negedge mclk);
		reg_req_valid = 1'b0;
		// a released bus must not keep showing the last word
		reg_req.wdata = ~wdata;
		rdata = reg_rdata;
	endtask : acc
endmodule : host_model

// *** bench/switch_input_irq_edge_config_bench.sv ***
`include "edge_irq_regs.svh"
module switch_input_irq_edge_config_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	edge_irq_pkg::reg_req_s reg_req;
	logic reg_req_valid;
	logic [23:0] reg_rdata;
	logic sample_valid = 1'b0;
	// second threshold, first threshold, assigned threshold
	logic [23:0] above = 24'h000000;
	wire [23:0] ev;
	logic irq_any;
	logic [23:0] rd;
	int n_fail = 0;
	int checks_done = 0;
	always #25 mclk = ~mclk;
	edge_irq_select edge_irq_select_i (.mclk(mclk), .reset_n(reset_n), .reg_req(reg_req),
		.reg_req_valid(reg_req_valid), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
		.above_assigned_threshold(above[11:0]), .above_pair_threshold_first(above[17:12]),
		.above_pair_threshold_second(above[23:18]), .chan_irq_event(ev[11:0]),
		.dual_irq_event_first(ev[17:12]), .dual_irq_event_second(ev[23:18]), .irq_any(irq_any));
	host_model host_model_i (.mclk(mclk), .reg_req(reg_req), .reg_req_valid(reg_req_valid), .reg_rdata(reg_rdata));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task samp(input logic [23:0] v, input logic valid, input logic [23:0] exp);
		@(negedge mclk);
		above = v;
		sample_valid = valid;
		@(negedge mclk);
		sample_valid = 1'b0;
		chk(ev, exp);
		chk({23'h0, irq_any}, {23'h0, |exp});
	endtask : samp
	task end_of_test;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(negedge mclk);
		reset_n = 1'b1;
		host_model_i.acc(1'b0, `EDGE_SEL_LOW_ADDR, 24'h000000, rd);
		chk(rd, 24'h000000);
		host_model_i.acc(1'b0, `EDGE_SEL_DUAL_ADDR, 24'h000000, rd);
		chk(rd, 24'h000000);
		// low register: channel i gets code i mod 4, so every code is set
		host_model_i.acc(1'b1, `EDGE_SEL_LOW_ADDR, 24'hE4E4E4, rd);
		chk(rd, 24'h000000);
		host_model_i.acc(1'b1, `EDGE_SEL_DUAL_ADDR, 24'h6D43E9, rd);
		host_model_i.acc(1'b1, 6'h27, 24'hFFFFFF, rd);
		host_model_i.acc(1'b0, 6'h27, 24'h000000, rd);
		chk(rd, 24'h000000);
		host_model_i.acc(1'b0, `EDGE_SEL_LOW_ADDR, 24'h000000, rd);
		chk(rd, 24'hE4E4E4);
		host_model_i.acc(1'b0, `EDGE_SEL_DUAL_ADDR, 24'h000000, rd);
		chk(rd, 24'h6D43E9);
		// priming sample, then a change that is never sampled
		samp(24'h000000, 1'b1, 24'h000000);
		samp(24'hFFFFFF, 1'b0, 24'h000000);
		samp(24'hFFFFFF, 1'b1, {6'h3A, 6'h15, 12'hAAA});
		samp(24'h000000, 1'b1, {6'h13, 6'h26, 12'hCCC});
		// reset in mid-run: selections clear and the next sample only primes
		@(negedge mclk);
		reset_n = 1'b0;
		repeat (2) @(negedge mclk);
		reset_n = 1'b1;
		host_model_i.acc(1'b0, `EDGE_SEL_DUAL_ADDR, 24'h000000, rd);
		chk(rd, 24'h000000);
		host_model_i.acc(1'b1, `EDGE_SEL_LOW_ADDR, 24'hE4E4E4, rd);
		chk(rd, 24'h000000);
		samp(24'hFFFFFF, 1'b1, 24'h000000);
		samp(24'h000000, 1'b1, 24'h000CCC);
		end_of_test();
	end
	initial begin
		#50000;
		n_fail++;
		end_of_test();
	end
endmodule : switch_input_irq_edge_config_bench
